// ==== core/rtcc_pkg.sv ====
// Package: offsets, field positions and timing constants of the RTC control block
package rtcc_pkg;
   // Register offsets on the byte bus
   localparam logic [6:0] ADDR_RATE = 7'h0A;
   localparam logic [6:0] ADDR_MODE = 7'h0B;
   localparam logic [6:0] ADDR_FLAGS = 7'h0C;
   localparam logic [6:0] ADDR_POWER = 7'h0D;
   localparam logic [6:0] ADDR_CENTURY = 7'h32;
   localparam logic [6:0] ADDR_RAM_LO = 7'h0E;
   // Field positions, mode register
   localparam int MODE_FREEZE = 7;
   localparam int MODE_PER_EN = 6;
   localparam int MODE_ALM_EN = 5;
   localparam int MODE_UPD_EN = 4;
   localparam int MODE_SQ_EN = 3;
   localparam int MODE_BIN = 2;
   localparam int MODE_H24 = 1;
   localparam int MODE_DST_EN = 0;
   // Field positions, flag register
   localparam int FLAG_REQ = 7;
   localparam int FLAG_PER = 6;
   localparam int FLAG_ALM = 5;
   localparam int FLAG_UPD = 4;
   // Power-up values of battery-backed registers
   localparam logic [7:0] RATE_POR = 8'h00;
   localparam logic [7:0] MODE_POR = 8'h00;
   localparam logic [7:0] CENTURY_POR = 8'h00;
   // Oscillator control patterns
   localparam logic [2:0] OSC_RUN = 3'b010;
   localparam logic [1:0] OSC_HOLD_HI = 2'b11;
   // Century reload value, BCD 20
   localparam logic [6:0] CENTURY_LOAD = 7'h20;
   // Divider chain
   localparam int DIV_STAGES = 15;
   localparam int OSC_HZ = 32768;
   // Update-pending lead time and its count of oscillator ticks, rounded up
   localparam int PEND_LEAD_US = 244;
   localparam int PEND_LEAD_TICKS = (PEND_LEAD_US * OSC_HZ + 999999) / 1000000;
   // Alarm don't-care marker in the two top bits
   localparam logic [1:0] ALM_ANY = 2'b11;
   // Daylight saving calendar values
   localparam logic [7:0] MONTH_APR = 8'h04;
   localparam logic [7:0] MONTH_OCT = 8'h0A;
   localparam logic [7:0] BCD_OCT = 8'h10;
   localparam logic [2:0] DOW_SUNDAY = 3'd1;
endpackage

// ==== core/rtcc_ctrl.sv ====
// Control and status registers of a battery-backed real-time clock
//
// Operation
// - Read-only update-pending bit, warns 244us ahead
// - Freeze bit inhibits transfers, clears update-pending
// - Pattern 010 runs; 11x holds chain reset
// - Other oscillator patterns keep oscillator stopped
// - First update 500ms after running pattern
// - Rate selector picks divider tap, reset-proof
// - Rate code decode, 8192Hz down to 2Hz
// - Freeze stops visible once-per-second transfers
// - Periodic enable gates periodic flag onto output
// - Alarm flag on match, 11xxxxxx matches all
// - Update-done enable cleared by reset or freeze
// - Square-wave pin follows tap or held low
// - Binary/BCD select bit, reset-proof
// - 24/12 hour select bit, reset-proof
// - Spring: 1:59:59 steps to 3:00:00
// - Fall: first 1:59:59 goes back once
// - Sunday test at midnight; enable reset-proof
// - Request flag and low output from enabled flags
// - Periodic flag sets on every rising tap edge
// - Alarm and update-done flags set regardless of enable
// - Flag read clears flags; reset clears too
// - Flags stable during read, late events held
// - Unused flag and power bits read zero
// - Backup-valid bit read-only, reset-proof
// - Year 99 to 00 loads century 20
// - Control registers and RAM always accessible
`timescale 1ns/1ps
module rtcc_ctrl #(
   parameter int RAM_DEPTH = 128
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic por_n,
   input wire logic osc_in,
   input wire logic backup_ok,
   input wire logic [6:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   input wire logic [7:0] cur_sec,
   input wire logic [7:0] cur_min,
   input wire logic [7:0] cur_hour,
   input wire logic [7:0] alm_sec,
   input wire logic [7:0] alm_min,
   input wire logic [7:0] alm_hour,
   input wire logic [7:0] cur_date,
   input wire logic [7:0] cur_month,
   input wire logic [2:0] cur_dow,
   input wire logic year_rollover,
   output logic update_xfer,
   output logic dst_step_fwd,
   output logic dst_step_back,
   output logic irq_n,
   output logic square_wave_pin,
   output logic osc_enabled,
   output logic binary_format_select,
   output logic hour_24_select
);
   import rtcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////////////
   // Battery-backed copies; pin reset clears only the periodic, alarm, update-done and square-wave enables and flags
   logic [7:0] rate_r; // Oscillator control and rate selector
   logic [7:0] mode_r; // Freeze, enables and formats
   logic [7:0] mode_nxt; // Next mode value
   logic [2:0] flags_r; // Periodic, alarm, update-done flags
   logic [7:0] century_r; // Century byte
   logic [7:0] ram_r [RAM_DEPTH]; // General-purpose bytes
   logic [7:0] rdata_r; // Read data, latched at the read strobe
   logic [1:0] osc_sync_r; // Oscillator pin synchroniser
   logic [1:0] vbat_sync_r; // Backup-valid pin synchroniser
   logic osc_last_r; // Previous synchronised oscillator level
   logic [DIV_STAGES-1:0] div_r; // Count-up divider chain
   logic tap_last_r; // Previous selected tap level
   logic fall_done_r; // Fall-back already applied this day
   logic spring_day_r; // Today is the first Sunday of April
   logic fall_day_r; // Today is the last Sunday of October
   logic midnight_last_r; // Previous midnight match
   logic dst_fwd_r; // Spring step strobe
   logic dst_back_r; // Fall step strobe
   logic upd_r; // Registered update transfer pulse

   ////////////////////////////////////////////////////////////////////////////
   // Functions
   ////////////////////////////////////////////////////////////////////////////
   // Tap index for a rate code; 15 means no output
   function automatic logic [3:0] tap_of(input logic [3:0] code);
      logic [3:0] t;
      t = 4'd15;
      case (code)
         4'h0: t = 4'd15;
         4'h1, 4'h8: t = 4'd6;
         4'h2, 4'h9: t = 4'd7;
         default: t = code - 4'd2;
      endcase
      return t;
   endfunction

   // Alarm byte matches its time byte or is don't-care
   function automatic logic alm_hit(input logic [7:0] a, input logic [7:0] c);
      return (a[7:6] == ALM_ANY) || (a == c);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   ////////////////////////////////////////////////////////////////////////////
   wire sel_rate = (bus_addr == ADDR_RATE);
   wire sel_mode = (bus_addr == ADDR_MODE);
   wire sel_flags = (bus_addr == ADDR_FLAGS);
   wire sel_power = (bus_addr == ADDR_POWER);
   wire sel_cent = (bus_addr == ADDR_CENTURY);
   wire sel_ram = (bus_addr >= ADDR_RAM_LO) && !sel_cent;
   wire wr_rate = bus_wr && sel_rate;
   wire wr_mode = bus_wr && sel_mode;
   wire rd_flags = bus_rd && sel_flags;

   // Oscillator runs on 010 and 11x only
   wire [2:0] osc_ctrl = rate_r[6:4];
   wire osc_hold = (osc_ctrl[2:1] == OSC_HOLD_HI);
   wire osc_on = (osc_ctrl == OSC_RUN) || osc_hold;
   wire chain_run = (osc_ctrl == OSC_RUN);
   // Writing the running pattern from any other restarts the chain
   wire run_start = wr_rate && (bus_wdata[6:4] == OSC_RUN) && !chain_run;

   // Oscillator edge, seen only after two flip-flops
   // Gated after the synchroniser so no logic touches the raw pin
   wire osc_edge = osc_sync_r[1] && !osc_last_r && osc_on;
   wire div_step = osc_edge && chain_run;
   wire [DIV_STAGES-1:0] div_inc = div_r + 1'b1;

   // Update fires when the top stage rises: 500ms from a cleared chain
   wire upd_tick = div_step && !div_r[DIV_STAGES-1] && div_inc[DIV_STAGES-1];
   wire freeze = mode_r[MODE_FREEZE];
   wire xfer = upd_tick && !freeze;

   // Pending while within the lead window before the top stage rises
   wire [DIV_STAGES-2:0] lead_start =
      (DIV_STAGES-1)'((1 << (DIV_STAGES-1)) - PEND_LEAD_TICKS);
   // Never stored, so a write to its bit cannot set it; freeze or a stopped chain clears it
   wire update_pending = chain_run && !freeze && !div_r[DIV_STAGES-1] &&
              (div_r[DIV_STAGES-2:0] >= lead_start);

   // Selected tap shared by square wave and periodic flag
   wire [3:0] tap_idx = tap_of(rate_r[3:0]);
   wire tap_lvl = (tap_idx == 4'd15) ? 1'b0 : div_r[tap_idx];
   wire tap_edge = chain_run && tap_lvl && !tap_last_r;

   // Alarm compared at each update cycle
   wire alarm_ev = upd_tick && alm_hit(alm_sec, cur_sec) && alm_hit(alm_min, cur_min) &&
                   alm_hit(alm_hour, cur_hour);
   wire [2:0] events = {tap_edge, alarm_ev, upd_tick};

   // Interrupt request from enabled flags, no extra stage
   // Order matches the flag bits: periodic, alarm, update-done
   wire [2:0] irq_en = mode_r[MODE_PER_EN:MODE_UPD_EN];
   wire req = |(flags_r[2:0] & irq_en);

   // Daylight saving: calendar test at midnight, 1:59:59 at update
   wire oct = (cur_month == MONTH_OCT) || (cur_month == BCD_OCT);
   wire sunday = (cur_dow == DOW_SUNDAY);
   wire [7:0] date_25 = binary_format_select ? 8'h19 : 8'h25;
   wire midnight = (cur_hour == 8'h00) || (!hour_24_select && cur_hour == 8'h12);
   wire midnight_ev = midnight && !midnight_last_r;
   wire [7:0] min59 = binary_format_select ? 8'h3B : 8'h59;
   wire at_159 = (cur_hour == 8'h01) && (cur_min == min59) && (cur_sec == min59);
   // Enable is looked at both at midnight and at 1:59:59
   wire dst_en = mode_r[MODE_DST_EN];
   wire fwd_ev = xfer && dst_en && spring_day_r && at_159;
   wire back_ev = xfer && dst_en && fall_day_r && at_159 && !fall_done_r;

   // Read mux; unused bits return zero
   // The read edge latches the flags before their clear lands
   wire [7:0] rd_mux =
      sel_rate ? {update_pending, rate_r[6:0]} :
      sel_mode ? mode_r :
      sel_flags ? {req, flags_r[2:0], 4'h0} :
      sel_power ? {vbat_sync_r[1], 7'h00} :
      sel_cent ? century_r :
      sel_ram ? ram_r[bus_addr] : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Battery-backed control: pin reset clears only the periodic, alarm, update-done and square-wave enables
   ////////////////////////////////////////////////////////////////////////////
   // Rate register; update-pending bit is never stored
   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         rate_r <= RATE_POR;
      end else if (wr_rate) begin
         rate_r <= {1'b0, bus_wdata[6:0]};
      end
   end

   // Century, loaded with 20 on year rollover, top bit kept
   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         century_r <= CENTURY_POR;
      end else if (bus_wr && sel_cent) begin
         century_r <= bus_wdata;
      end else if (year_rollover) begin
         century_r <= {century_r[7], CENTURY_LOAD};
      end
   end

   // Mode register; pin reset clears only the four enables
   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         mode_r <= MODE_POR;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Next mode: host write, freeze rule, then pin reset on top
   always_comb begin
      mode_nxt = mode_r;
      if (wr_mode) begin
         mode_nxt = bus_wdata;
         // Freeze rising drops the update-done enable
         if (bus_wdata[MODE_FREEZE] && !mode_r[MODE_FREEZE]) begin
            mode_nxt[MODE_UPD_EN] = 1'b0;
         end
      end
      // Held pin reset clears the periodic, alarm, update-done and square-wave enables every cycle
      // Applied last, so it beats a host write in the same cycle
      if (!nrst) begin
         mode_nxt[MODE_PER_EN:MODE_SQ_EN] = 4'h0;
      end
   end

   // General-purpose bytes, no reset
   always_ff @(posedge ref_clk) begin
      if (bus_wr && sel_ram) begin
         ram_r[bus_addr] <= bus_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Divider chain and synchronisers
   ////////////////////////////////////////////////////////////////////////////
   // Pins pass two flip-flops before use
   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         osc_sync_r <= 2'b00;
         vbat_sync_r <= 2'b00;
         osc_last_r <= 1'b0;
      end else begin
         osc_sync_r <= {osc_sync_r[0], osc_in};
         // Backup level synchronised the same way, never gated
         vbat_sync_r <= {vbat_sync_r[0], backup_ok};
         osc_last_r <= osc_sync_r[1];
      end
   end

   // Chain held clear unless running; restart gives the 500ms lead
   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         div_r <= '0;
         tap_last_r <= 1'b0;
      end else begin
         tap_last_r <= tap_lvl;
         if (!chain_run || run_start) begin
            div_r <= '0;
         end else if (div_step) begin
            div_r <= div_inc;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags and read data
   ////////////////////////////////////////////////////////////////////////////
   // Set wins over read clear, so a late event lands after the read
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         flags_r <= 3'h0;
      end else begin
         // Request bit is not stored; it is rebuilt from flags and enables
         flags_r <= (rd_flags ? 3'b000 : flags_r) | events;
      end
   end

   // Read data captured at the strobe, stable afterwards
   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         rdata_r <= 8'h00;
      end else if (bus_rd) begin
         rdata_r <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Daylight saving and update strobes
   ////////////////////////////////////////////////////////////////////////////
   // Sunday test once at midnight; fall-back only once per day
   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         spring_day_r <= 1'b0;
         fall_day_r <= 1'b0;
         fall_done_r <= 1'b0;
         midnight_last_r <= 1'b0;
         dst_fwd_r <= 1'b0;
         dst_back_r <= 1'b0;
         upd_r <= 1'b0;
      end else begin
         midnight_last_r <= midnight;
         dst_fwd_r <= fwd_ev;
         dst_back_r <= back_ev;
         upd_r <= xfer;
         // Day type decided once, at the first midnight cycle
         if (midnight_ev) begin
            spring_day_r <= dst_en && sunday && (cur_month == MONTH_APR) &&
                            (cur_date <= 8'h07);
            fall_day_r <= dst_en && sunday && oct && (cur_date >= date_25);
            // Rearm the once-only fall-back for the new day
            fall_done_r <= 1'b0;
         end else if (back_ev) begin
            fall_done_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////////////
   assign bus_rdata = rdata_r;
   assign update_xfer = upd_r;
   assign dst_step_fwd = dst_fwd_r;
   assign dst_step_back = dst_back_r;
   assign irq_n = !req;
   // Square wave held low whenever its enable is off
   assign square_wave_pin = mode_r[MODE_SQ_EN] && tap_lvl;
   assign osc_enabled = osc_on;
   assign binary_format_select = mode_r[MODE_BIN];
   assign hour_24_select = mode_r[MODE_H24];

endmodule // rtcc_ctrl

// ==== sim/rtcc_ctrl_monitor.sv ====
// Port-level checker for the RTC control block
`timescale 1ns/1ps
module rtcc_ctrl_monitor #(
   parameter int RAM_DEPTH = 128
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic por_n,
   input wire logic backup_ok,
   input wire logic [6:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic update_xfer,
   input wire logic dst_step_fwd,
   input wire logic dst_step_back,
   input wire logic irq_n,
   input wire logic square_wave_pin,
   input wire logic osc_enabled,
   input wire logic binary_format_select,
   input wire logic hour_24_select
);
   import rtcc_pkg::*;
   ////////////////////////////////////////////////////////////////
   // Checks run on the bus clock, quiet in either reset; the two reset checks quiet only in power-on reset
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst || !por_n);
   // Decoded strobes
   wire wr_mode = bus_wr && bus_addr == ADDR_MODE;
   wire wr_rate = bus_wr && bus_addr == ADDR_RATE;
   wire rd_pwr = bus_rd && bus_addr == ADDR_POWER;
   ////////////////////////////////////////////////////////////////
   mode_fmt_a: assert property (wr_mode |=>
      binary_format_select == $past(bus_wdata[MODE_BIN]) && hour_24_select == $past(
      bus_wdata[MODE_H24])) else $error("format outputs do not follow mode write");
   sq_off_a: assert property (wr_mode && !bus_wdata[MODE_SQ_EN] |=> !square_wave_pin)
      else $error("square wave not held low");
   irq_gate_a: assert property (wr_mode && bus_wdata[6:4] == 3'b000 |=> irq_n)
      else $error("interrupt low with all enables off");
   osc_ctrl_a: assert property (wr_rate |=> osc_enabled ==
      ($past(bus_wdata[6:4]) == OSC_RUN || $past(bus_wdata[6:5]) == OSC_HOLD_HI))
      else $error("oscillator enable wrong for pattern");
   flag_low_a: assert property (bus_rd && bus_addr == ADDR_FLAGS |=> bus_rdata[3:0] == 4'h0)
      else $error("flag register low bits not zero");
   pwr_low_a: assert property (rd_pwr |=> bus_rdata[6:0] == 7'h00)
      else $error("power register low bits not zero");
   valid_bit_a: assert property ($stable(backup_ok) [*4] ##0 rd_pwr |=>
      bus_rdata[7] == $past(backup_ok)) else $error("backup valid bit wrong");
   rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
      else $error("read data changed without a read");
   freeze_hold_a: assert property (wr_mode && bus_wdata[MODE_FREEZE] |=> ##1 !update_xfer [*8])
      else $error("transfer while frozen");
   xfer_pulse_a: assert property (update_xfer |=> !update_xfer)
      else $error("transfer pulse too long");
   dst_excl_a: assert property (!(dst_step_fwd && dst_step_back))
      else $error("both daylight steps at once");
   rst_irq_a: assert property (@(posedge ref_clk) disable iff (!por_n) !nrst |-> irq_n)
      else $error("interrupt active in reset");
   rst_sq_a: assert property (@(posedge ref_clk) disable iff (!por_n)
      !nrst [*2] |-> !square_wave_pin) else $error("square wave active in reset");
endmodule // rtcc_ctrl_monitor
bind rtcc_ctrl rtcc_ctrl_monitor #(.RAM_DEPTH(RAM_DEPTH)) u_mon (.ref_clk, .nrst, .por_n,
   .backup_ok, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .update_xfer, .dst_step_fwd,
   .dst_step_back, .irq_n, .square_wave_pin, .osc_enabled, .binary_format_select,
   .hour_24_select);

// ==== sim/rtcc_host.sv ====
// Host processor model driving the byte bus
`timescale 1ns/1ps
module rtcc_host (
   input wire logic ref_clk,
   output logic [6:0] bus_addr,
   output logic [7:0] bus_wdata,
   output logic bus_wr,
   output logic bus_rd
);
   // Idle bus from time zero
   initial begin
      bus_addr = 7'h7F;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   end
   // One cycle, held across one sampling edge; released address and data show inverse, strobes low
   task automatic cyc(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      bus_addr = a;
      bus_wdata = d;
      bus_wr = w;
      bus_rd = !w;
      @(posedge ref_clk);
      #1;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
   endtask
endmodule // rtcc_host

// ==== sim/tb.sv ====
// Self-checking bench of the RTC control block
`timescale 1ns/1ps
module tb;
   import rtcc_pkg::*;
   logic ref_clk, nrst, por_n, osc_in, backup_ok, year_rollover, irq_n, sq_pin, rd_d = 1'b0;
   logic [7:0] bus_rdata, sec, mn, hr, asec, amin, ahr, date, month;
   logic [2:0] dow;
   logic [6:0] bus_addr;
   logic [7:0] bus_wdata;
   logic bus_wr, bus_rd;
   logic [31:0] lfsr_r = 32'h0000_3717;
   logic [7:0] exp_q[$];
   int n_mismatch = 0;
   int samples_checked = 0;
   ////////////////////////////////////////////////////////////////
   rtcc_host u_host (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd));
   rtcc_ctrl #(.RAM_DEPTH(128)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .por_n(por_n),
      .osc_in(osc_in), .backup_ok(backup_ok), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .cur_sec(sec),
      .cur_min(mn), .cur_hour(hr), .alm_sec(asec), .alm_min(amin), .alm_hour(ahr),
      .cur_date(date), .cur_month(month), .cur_dow(dow),
      .year_rollover(year_rollover), .update_xfer(), .dst_step_fwd(), .dst_step_back(),
      .irq_n(irq_n), .square_wave_pin(sq_pin), .osc_enabled(), .binary_format_select(),
      .hour_24_select());
   ////////////////////////////////////////////////////////////////
   // Bus clock and a fast stand-in crystal, so divider taps toggle soon
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      osc_in = 1'b0;
      forever #30 osc_in = ~osc_in;
   end
   // Next pseudo-random byte
   function automatic logic [7:0] rnd();
      lfsr_r = {lfsr_r[30:0], 1'b0} ^ (lfsr_r[31] ? 32'h0040_0007 : 32'h0000_0000);
      return lfsr_r[7:0];
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Read with its expectation noted first
   task automatic rd_exp(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.cyc(1'b0, a, 8'h00);
   endtask
   // Read data is valid the cycle after the taken edge
   always @(posedge ref_clk) rd_d <= bus_rd;
   always @(negedge ref_clk) begin
      if (rd_d && exp_q.size() > 0) check("read data", bus_rdata, exp_q.pop_front());
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Watchdog, well past the expected run length
   initial begin
      #400_000;
      n_mismatch++;
      report_and_stop;
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d, a;
      logic hi, lo;
      {nrst, por_n, backup_ok, year_rollover} = 4'b0010;
      sec = rnd();
      mn = rnd();
      asec = rnd();
      amin = rnd();
      {hr, ahr, date, month, dow} = {8'h05, 8'hC0, 8'h03, MONTH_APR, DOW_SUNDAY}; // Not midnight
      repeat (12) @(posedge ref_clk);
      #1;
      {nrst, por_n} = 2'b11;
      rd_exp(ADDR_RATE, RATE_POR);
      rd_exp(ADDR_MODE, MODE_POR);
      rd_exp(ADDR_FLAGS, 8'h00);
      rd_exp(ADDR_POWER, 8'h80);
      rd_exp(ADDR_CENTURY, CENTURY_POR);
      rd_exp(7'h05, 8'h00);
      $display("reset values done");
      for (int i = 0; i < 6; i++) begin
         d = rnd();
         a = rnd();
         a = ADDR_RAM_LO + (a % 8'h24);
         u_host.cyc(1'b1, a[6:0], d);
         rd_exp(a[6:0], d);
      end
      u_host.cyc(1'b1, ADDR_FLAGS, 8'hFF);
      u_host.cyc(1'b1, ADDR_POWER, 8'h7F);
      u_host.cyc(1'b1, ADDR_RATE, 8'h8A);
      rd_exp(ADDR_FLAGS, 8'h00);
      rd_exp(ADDR_RATE, 8'h0A);
      backup_ok = 1'b0;
      rd_exp(ADDR_MODE, MODE_POR);
      rd_exp(ADDR_POWER, 8'h00);
      backup_ok = 1'b1;
      $display("ram and read-only done");
      u_host.cyc(1'b1, ADDR_MODE, 8'h7F); // Daylight enable set ahead of the pin reset
      rd_exp(ADDR_MODE, 8'h7F);
      check("irq idle", {7'h00, irq_n}, 8'h01);
      nrst = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      rd_exp(ADDR_MODE, 8'h07);
      rd_exp(ADDR_RATE, 8'h0A);
      u_host.cyc(1'b1, ADDR_MODE, 8'h10);
      u_host.cyc(1'b1, ADDR_MODE, 8'h90);
      rd_exp(ADDR_MODE, 8'h80);
      $display("mode and reset done");
      // Each short rate code: square wave and periodic flag
      u_host.cyc(1'b1, ADDR_MODE, 8'h08);
      u_host.cyc(1'b1, ADDR_RATE, 8'h03);
      for (int c = 0; c < 10; c++) begin
         u_host.cyc(1'b1, ADDR_RATE, {1'b0, OSC_RUN, c[3:0]});
         {hi, lo} = 2'b00;
         repeat (800) begin
            @(posedge ref_clk);
            #1;
            hi |= sq_pin;
            lo |= !sq_pin;
         end
         check("square wave", {6'h00, hi, lo}, (c == 0) ? 8'h01 : 8'h03);
         rd_exp(ADDR_FLAGS, (c == 0) ? 8'h00 : 8'h40);
      end
      // Fast tap for some edges so the periodic flag sets, then stop the chain
      u_host.cyc(1'b1, ADDR_RATE, 8'h23);
      repeat (40) @(posedge ref_clk);
      u_host.cyc(1'b1, ADDR_RATE, 8'h03);
      u_host.cyc(1'b1, ADDR_MODE, 8'h40);
      check("irq periodic", {7'h00, irq_n}, 8'h00);
      rd_exp(ADDR_FLAGS, 8'hC0);
      rd_exp(ADDR_FLAGS, 8'h00);
      check("irq cleared", {7'h00, irq_n}, 8'h01);
      $display("rates and interrupt done");
      u_host.cyc(1'b1, ADDR_CENTURY, 8'h85);
      year_rollover = 1'b1;
      @(posedge ref_clk);
      #1;
      year_rollover = 1'b0;
      rd_exp(ADDR_CENTURY, 8'hA0);
      $display("century done");
      repeat (4) @(posedge ref_clk);
      report_and_stop;
   end
endmodule // tb
